// ===== include/rcfe_pkg.sv
// package: constants and types of the remote-control front end
package rcfe_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_BUS_ADDR = 8'h08;
  localparam logic [7:0] OFF_GP_OUT   = 8'h0c;
  localparam logic [7:0] OFF_GP_IN    = 8'h10;
  localparam logic [7:0] OFF_MEAS     = 8'h14;
  localparam logic [7:0] OFF_QUERY    = 8'h18;
  localparam logic [7:0] OFF_BUS_CMD  = 8'h1c;
  localparam logic [7:0] OFF_FUNC     = 8'h20;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_BUS     = 0;
  localparam int CTRL_SINGLE      = 1;
  localparam int CMD_ADDRESSED    = 0;
  localparam int CMD_GTL          = 1;
  localparam int CMD_LLO          = 2;
  localparam int CMD_QUERY        = 3;
  localparam int MEAS_DONE        = 0;
  localparam int MEAS_FAULT       = 1;
  localparam int MEAS_VERDICT_LSB = 2;
  localparam int MEAS_TWO_LIMITS  = 7;
  localparam int MEAS_RANGE_TRIED = 8;
  localparam int N_FUNC           = 6;
  localparam int FUNC_MEAS        = 0;
  localparam int FUNC_STROBE      = 5;

  localparam logic [4:0] BUS_ADDR_DEFAULT = 5'h09;
  localparam logic [4:0] BUS_ADDR_MAX     = 5'h1e;
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int EOM_DELAY_US    = 1000;
  localparam int EOM_DELAY_CYC   = EOM_DELAY_US * CLK_MHZ;
  localparam int SINGLE_MEAS_US  = 2000;
  localparam int SINGLE_MEAS_CYC = SINGLE_MEAS_US * CLK_MHZ;
  localparam int DEBOUNCE_US     = 100;
  localparam int DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;

  typedef enum logic [1:0] {RL_LOCAL, RL_REMOTE, RL_LOCKED} rcfe_rl_t;

endpackage

// ===== src/rcfe_debounce.sv
// module: two-stage synchroniser and bounce filter for one controller input
`timescale 1ns/1ps
module rcfe_debounce #(
  parameter int CYCLES = 10000
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw input and filtered level
  input  wire logic raw,
  output logic      level
);
  logic        sync_a;
  logic        sync_b;
  logic [15:0] cnt;
  wire         differs = sync_b != level;
  wire         settled = cnt == 16'(CYCLES - 1);

  always_ff @(posedge aclk)
  begin
    sync_a <= raw;
    sync_b <= sync_a;
  end

  // the level changes only after the input has stood still for CYCLES
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !differs)
      cnt <= 16'h0000;
    else
      cnt <= cnt + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level <= 1'b0;
    else if (differs && settled)
      level <= sync_b;
  end
endmodule

// ===== src/rcfe_top.sv
// module: remote-control front end with bus remote/local and controller port
`timescale 1ns/1ps
// Function
// RULE1: bus address settable 0..30, default 9.
// RULE2: new address takes effect at once.
// RULE3: bus port selectable only when bus card is fitted.
// RULE4: any addressed bus command enters remote state. (Here an addressed go-to-local command leaves the state local.)
// RULE5: in remote, keys ignored except the return-to-local key.
// RULE6: return-to-local key or go-to-local message returns to local.
// RULE7: after local lockout only go-to-local restores local.
// RULE8: query places value in output buffer; controller reads it.
// RULE9: all controller port lines are active high.
// RULE10: six control inputs: measure, comparator, logger, max/min, printer, strobe.
// RULE11: five setup-select inputs form binary number, input zero lsb.
// RULE12: four general inputs readable only while measurement stopped.
// RULE13: drive end, fault, busy flags and five verdicts; two-limit outer verdicts.
// RULE14: three general outputs changeable only while measurement stopped.
// RULE15: each contact closure toggles measurement; single restarts after time elapsed. (Here a closure starts measurement only in single mode.)
// RULE16: five relay contacts mirror comparator verdicts.
// RULE17: controller contacts test object before asserting start.
// RULE18: controller should use manual range and single mode.
// RULE19: autorange error measuring time is ranges tried times single time.
// RULE20: all controller port outputs low at power-on.
// RULE21: rising edge activates function, falling edge terminates it.
// RULE22: end flag rises about 1 ms after results are set.
// RULE23: synchronise and debounce every controller input before edge detection.
module rcfe_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // front panel and bus option
  input  wire logic        bus_card_fitted,
  input  wire logic [7:0]  panel_keys,
  input  wire logic        return_to_local_key,
  output logic [7:0]       panel_keys_accepted,
  output logic             remote_state,
  // controller port inputs
  input  wire logic [4:0]  plc_func_in,
  input  wire logic        plc_strobe_in,
  input  wire logic [4:0]  plc_setup_sel,
  input  wire logic [3:0]  plc_gp_in,
  input  wire logic        plc_contact,
  // controller port outputs and relays
  output logic             plc_end_of_meas,
  output logic             plc_fault,
  output logic             plc_busy,
  output logic [4:0]       plc_verdict,
  output logic [2:0]       plc_gp_out,
  output logic [4:0]       relay,
  // measurement engine side
  output logic [4:0]       func_active,
  output logic             setup_load,
  output logic [4:0]       setup_index
);
  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  localparam int N_IN = 16;
  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] filt;
  logic [N_IN-1:0] filt_d;
  assign raw_in = {plc_contact, plc_gp_in, plc_setup_sel, plc_strobe_in, plc_func_in};

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_in
      rcfe_debounce #(.CYCLES(rcfe_pkg::DEBOUNCE_CYC)) u_deb ( // RULE23
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (raw_in[gi]),
        .level   (filt[gi])
      );
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      filt_d <= '0;
    else
      filt_d <= filt;
  end

  // high level means asserted throughout
  wire [N_IN-1:0] rise      = filt & ~filt_d;               // RULE9
  wire [N_IN-1:0] fall      = ~filt & filt_d;
  wire [5:0]      func_rise = rise[5:0];                    // RULE10
  wire            contact_close = rise[15];
  wire [4:0]      sel_now   = filt[10:6];                   // RULE11
  wire [3:0]      gp_now    = filt[14:11];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        ar_take  = s_axi_arvalid && s_axi_arready;
  wire        wr_ok    = aw_addr <= rcfe_pkg::OFF_FUNC && aw_addr[1:0] == 2'b00;
  wire        rd_ok    = s_axi_araddr <= rcfe_pkg::OFF_FUNC && s_axi_araddr[1:0] == 2'b00;
  wire        wr_lo    = do_write && w_strb[0];
  wire        wr_ctrl  = wr_lo && aw_addr == rcfe_pkg::OFF_CTRL;
  wire        wr_addr  = wr_lo && aw_addr == rcfe_pkg::OFF_BUS_ADDR;
  wire        wr_gpo   = wr_lo && aw_addr == rcfe_pkg::OFF_GP_OUT;
  wire        wr_meas  = do_write && aw_addr == rcfe_pkg::OFF_MEAS && w_strb[1:0] == 2'b11;
  wire        wr_query = do_write && aw_addr == rcfe_pkg::OFF_QUERY && w_strb == 4'hf;
  wire        wr_cmd   = wr_lo && aw_addr == rcfe_pkg::OFF_BUS_CMD;
  wire        wr_func  = wr_lo && aw_addr == rcfe_pkg::OFF_FUNC;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rcfe_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? rcfe_pkg::RESP_OKAY : rcfe_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  // ----------------------------------------------------------------
  // configuration and bus remote/local
  // ----------------------------------------------------------------
  logic            sel_bus;
  logic            single_mode;
  logic [4:0]      bus_addr;
  logic [31:0]     out_buf;
  logic            out_buf_full;
  rcfe_pkg::rcfe_rl_t rl_state;
  logic [4:0]      func_on;

  // out-of-range addresses are dropped, keeping the old one live
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus_addr <= rcfe_pkg::BUS_ADDR_DEFAULT;                 // RULE1
    else if (wr_addr && w_data[4:0] <= rcfe_pkg::BUS_ADDR_MAX)
      bus_addr <= w_data[4:0];                                // RULE2
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_bus     <= 1'b0;
      single_mode <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      sel_bus     <= w_data[rcfe_pkg::CTRL_SEL_BUS] && bus_card_fitted; // RULE3
      single_mode <= w_data[rcfe_pkg::CTRL_SINGLE];
    end
    else if (!bus_card_fitted)
      sel_bus <= 1'b0;                                        // RULE3
  end

  wire bus_cmd_addr = wr_cmd && sel_bus && w_data[rcfe_pkg::CMD_ADDRESSED]
                      && w_data[12:8] == bus_addr;
  wire cmd_gtl      = bus_cmd_addr && w_data[rcfe_pkg::CMD_GTL];
  wire cmd_llo      = bus_cmd_addr && w_data[rcfe_pkg::CMD_LLO];
  wire key_local    = return_to_local_key && rl_state == rcfe_pkg::RL_REMOTE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rl_state <= rcfe_pkg::RL_LOCAL;
    else
    begin
      case (rl_state)
        rcfe_pkg::RL_LOCAL:
          if (cmd_llo)
            rl_state <= rcfe_pkg::RL_LOCKED;                  // RULE7
          else if (bus_cmd_addr && !cmd_gtl)
            rl_state <= rcfe_pkg::RL_REMOTE;                  // RULE4
        rcfe_pkg::RL_REMOTE:
          if (cmd_gtl || key_local)
            rl_state <= rcfe_pkg::RL_LOCAL;                   // RULE6
          else if (cmd_llo)
            rl_state <= rcfe_pkg::RL_LOCKED;
        rcfe_pkg::RL_LOCKED:
          if (cmd_gtl)
            rl_state <= rcfe_pkg::RL_LOCAL;                   // RULE7
        default:
          rl_state <= rcfe_pkg::RL_LOCAL;
      endcase
    end
  end

  // panel keys pass only in local
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      panel_keys_accepted <= 8'h00;
      remote_state        <= 1'b0;
    end
    else
    begin
      panel_keys_accepted <= (rl_state == rcfe_pkg::RL_LOCAL) ? panel_keys : 8'h00; // RULE5
      remote_state        <= rl_state != rcfe_pkg::RL_LOCAL;
    end
  end

  // query value parked until the controller reads it
  wire rd_query = ar_take && s_axi_araddr == rcfe_pkg::OFF_QUERY;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_buf      <= 32'h0000_0000;
      out_buf_full <= 1'b0;
    end
    else if (wr_query)
    begin
      out_buf      <= w_data;                                 // RULE8
      out_buf_full <= 1'b1;
    end
    else if (rd_query)
      out_buf_full <= 1'b0;                                   // RULE8
  end

  // ----------------------------------------------------------------
  // measurement control
  // ----------------------------------------------------------------
  logic        measuring;
  logic [31:0] meas_timer;
  logic [16:0] eom_cnt;
  logic        eom_pend;
  logic [4:0]  next_verdict;
  wire         meas_rise   = func_rise[rcfe_pkg::FUNC_MEAS];
  wire         meas_fall   = fall[rcfe_pkg::FUNC_MEAS];
  wire         time_done   = meas_timer == 32'h0000_0000;
  wire         toggle_start = contact_close && !measuring && single_mode && time_done;
  wire         toggle_stop  = contact_close && measuring;        // RULE15
  wire         start_meas  = meas_rise || toggle_start;
  wire         stop_meas   = meas_fall || toggle_stop;         // RULE21
  wire [3:0]   n_ranges    = w_data[rcfe_pkg::MEAS_RANGE_TRIED +: 4];
  wire         two_limits  = w_data[rcfe_pkg::MEAS_TWO_LIMITS];
  wire [4:0]   raw_verdict = w_data[rcfe_pkg::MEAS_VERDICT_LSB +: 5];

  // two limits: outer lines carry plain above and below
  assign next_verdict = two_limits ? {raw_verdict[4] | raw_verdict[3], 3'b000,
                                      raw_verdict[0] | raw_verdict[1]} : raw_verdict; // RULE13

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      measuring  <= 1'b0;
      meas_timer <= 32'h0000_0000;
    end
    else if (stop_meas)
    begin
      measuring  <= 1'b0;
      meas_timer <= 32'h0000_0000;
    end
    else if (start_meas && !measuring)
    begin
      measuring  <= 1'b1;
      meas_timer <= 32'(rcfe_pkg::SINGLE_MEAS_CYC);
    end
    else if (wr_meas && measuring)
    begin
      measuring  <= !single_mode;
      meas_timer <= 32'(n_ranges) * 32'(rcfe_pkg::SINGLE_MEAS_CYC); // RULE19
    end
    else if (!time_done)
      meas_timer <= meas_timer - 32'h0000_0001;
  end

  // results first, end flag about 1 ms later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      plc_verdict     <= 5'h00;                               // RULE20
      relay           <= 5'h00;
      plc_fault       <= 1'b0;
      plc_end_of_meas <= 1'b0;
      plc_busy        <= 1'b0;
      eom_pend        <= 1'b0;
      eom_cnt         <= 17'h00000;
    end
    else
    begin
      plc_busy <= measuring;                                  // RULE13
      if (wr_meas && measuring && w_data[rcfe_pkg::MEAS_DONE])
      begin
        plc_verdict <= next_verdict;
        relay       <= next_verdict;                          // RULE16
        plc_fault   <= w_data[rcfe_pkg::MEAS_FAULT];
        eom_pend    <= 1'b1;
        eom_cnt     <= 17'(rcfe_pkg::EOM_DELAY_CYC - 1);
        // continuous mode: every result needs its own rising edge
        plc_end_of_meas <= 1'b0;
      end
      else if (eom_pend && eom_cnt == 17'h00000)
      begin
        eom_pend        <= 1'b0;
        plc_end_of_meas <= 1'b1;                              // RULE22
      end
      else if (eom_pend)
        eom_cnt <= eom_cnt - 17'h00001;
      if (start_meas && !measuring)
      begin
        plc_end_of_meas <= 1'b0;
        eom_pend        <= 1'b0;
      end
    end
  end

  // general outputs and inputs only while stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      plc_gp_out <= 3'h0;
    else if (wr_gpo && !measuring)
      plc_gp_out <= w_data[2:0];                              // RULE14
  end

  // other functions follow edges, strobe loads the selected setup
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      func_on     <= 5'h00;
      setup_load  <= 1'b0;
      setup_index <= 5'h00;
      func_active <= 5'h00;
    end
    else
    begin
      func_on     <= (func_on | func_rise[4:0] | (wr_func ? w_data[4:0] : 5'h00))
                     & ~fall[4:0];                            // RULE21
      setup_load  <= func_rise[rcfe_pkg::FUNC_STROBE];        // RULE10
      if (func_rise[rcfe_pkg::FUNC_STROBE])
        setup_index <= sel_now;                               // RULE11
      func_active <= {func_on[4:1], measuring};
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      rcfe_pkg::OFF_CTRL:     rd_mux = {30'h0, single_mode, sel_bus};
      rcfe_pkg::OFF_STATUS:   rd_mux = {26'h0, out_buf_full, bus_card_fitted, rl_state,
                                        plc_end_of_meas, measuring};
      rcfe_pkg::OFF_BUS_ADDR: rd_mux = {27'h0, bus_addr};
      rcfe_pkg::OFF_GP_OUT:   rd_mux = {29'h0, plc_gp_out};
      rcfe_pkg::OFF_GP_IN:    rd_mux = measuring ? 32'h0 : {28'h0, gp_now}; // RULE12
      rcfe_pkg::OFF_QUERY:    rd_mux = out_buf;
      rcfe_pkg::OFF_FUNC:     rd_mux = {27'h0, func_on[4:1], measuring};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= rcfe_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? rcfe_pkg::RESP_OKAY : rcfe_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_addr_range;
    @(posedge aclk) disable iff (!aresetn) bus_addr <= 5'd30;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bus address out of range"); // RULE1

  property p_key_lock;
    @(posedge aclk) disable iff (!aresetn)
      rl_state == rcfe_pkg::RL_LOCKED && !cmd_gtl |=> rl_state == rcfe_pkg::RL_LOCKED;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("lockout left without go-to-local"); // RULE7

  property p_gpo_hold;
    @(posedge aclk) disable iff (!aresetn) measuring |=> $stable(plc_gp_out);
  endproperty
  a_gpo_hold: assert property (p_gpo_hold) else $error("general output changed while running"); // RULE14

  property p_keys_block;
    @(posedge aclk) disable iff (!aresetn)
      rl_state != rcfe_pkg::RL_LOCAL |=> panel_keys_accepted == 8'h00;
  endproperty
  a_keys_block: assert property (p_keys_block) else $error("panel key passed in remote"); // RULE5

  property p_gpin_hide;
    @(posedge aclk) disable iff (!aresetn)
      ar_take && s_axi_araddr == rcfe_pkg::OFF_GP_IN && measuring
      |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_gpin_hide: assert property (p_gpin_hide) else $error("general inputs read while running"); // RULE12

  sequence s_result;
    wr_meas && measuring && w_data[0];
  endsequence
  property p_eom_delay;
    @(posedge aclk) disable iff (!aresetn)
      s_result ##1 !start_meas [*8] |-> !plc_end_of_meas;
  endproperty
  a_eom_delay: assert property (p_eom_delay) else $error("end flag rose too early"); // RULE22
endmodule

// ===== sim/rcfe_plc_model.sv
// controller-port partner: drives the industrial-controller input lines
`timescale 1ns/1ps
module rcfe_plc_model (
  // clock
  input  wire logic aclk,
  // lines towards the device
  output logic [4:0] func,
  output logic       strobe,
  output logic [4:0] sel,
  output logic [3:0] gp,
  output logic       contact
);
  // --------------------------------------------------------------
  // line driver
  // --------------------------------------------------------------
  // all lines idle low until a scenario drives them
  initial
  begin
    func    = 5'h00;
    strobe  = 1'b0;
    sel     = 5'h00;
    gp      = 4'h0;
    contact = 1'b0;
  end

  // object contacted before start, manual single mode assumed
  task automatic set_lines(input logic [4:0] f, input logic s,
                           input logic [4:0] sl, input logic [3:0] g);
    @(posedge aclk);
    func   <= f;
    strobe <= s;
    sel    <= sl;
    gp     <= g;
  endtask

  // start/stop contact pair, closed while c is high
  task automatic set_contact(input logic c);
    @(posedge aclk);
    contact <= c;
  endtask
endmodule

// ===== sim/rcfe_top_tb.sv
// testbench: register tasks, remote/local and controller-port sequences
`timescale 1ns/1ps
module rcfe_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, keys = 8'h00, keys_ok;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, remote, rtl_key = 1'b0, card = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic eom, fault, busy, load, load_seen = 1'b0, strobe, contact;
  logic [4:0] func, sel, verdict, relay, fact, sidx;
  logic [3:0] gp;
  logic [2:0] gpo;
  int err_total = 0, checks = 0;

  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) if (load === 1'b1) load_seen <= 1'b1;

  rcfe_plc_model plc (.aclk(aclk), .func(func), .strobe(strobe), .sel(sel), .gp(gp),
    .contact(contact));

  rcfe_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_card_fitted(card), .panel_keys(keys),
    .return_to_local_key(rtl_key), .panel_keys_accepted(keys_ok),
    .remote_state(remote), .plc_func_in(func), .plc_strobe_in(strobe),
    .plc_setup_sel(sel), .plc_gp_in(gp), .plc_contact(contact),
    .plc_end_of_meas(eom), .plc_fault(fault), .plc_busy(busy),
    .plc_verdict(verdict), .plc_gp_out(gpo), .relay(relay), .func_active(fact),
    .setup_load(load), .setup_index(sidx));

  // ----------------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, rcfe_pkg::RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdt(a, rd, rs);
    chk(rd, e);
  endtask

  // filter settles after 2 sync flops, 10000 stable cycles and edge detect
  task automatic settle();
    repeat (10010) @(posedge aclk);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge aclk);
    err_total++;
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk({eom, fault, busy, verdict, gpo, relay}, 32'h0);
    rchk(rcfe_pkg::OFF_BUS_ADDR, 32'h9);
    wchk(rcfe_pkg::OFF_BUS_ADDR, 32'h1f);
    rchk(rcfe_pkg::OFF_BUS_ADDR, 32'h9);
    wchk(rcfe_pkg::OFF_BUS_ADDR, 32'h1e);
    rchk(rcfe_pkg::OFF_BUS_ADDR, 32'h1e);
    wchk(rcfe_pkg::OFF_CTRL, 32'h3);
    rchk(rcfe_pkg::OFF_CTRL, 32'h2);
    card <= 1'b1;
    wchk(rcfe_pkg::OFF_CTRL, 32'h3);
    rchk(rcfe_pkg::OFF_CTRL, 32'h3);
    keys <= 8'h5a;
    wchk(rcfe_pkg::OFF_BUS_CMD, 32'h0901);
    rchk(rcfe_pkg::OFF_STATUS, 32'h10);
    wchk(rcfe_pkg::OFF_BUS_CMD, 32'h1e01);
    rchk(rcfe_pkg::OFF_STATUS, 32'h14);
    chk({23'h0, remote, keys_ok}, 32'h100);
    rtl_key <= 1'b1;
    repeat (5) @(posedge aclk);
    rtl_key <= 1'b0;
    rchk(rcfe_pkg::OFF_STATUS, 32'h10);
    chk({23'h0, remote, keys_ok}, 32'h5a);
    wchk(rcfe_pkg::OFF_BUS_CMD, 32'h1e05);
    rtl_key <= 1'b1;
    repeat (5) @(posedge aclk);
    rtl_key <= 1'b0;
    rchk(rcfe_pkg::OFF_STATUS, 32'h18);
    wchk(rcfe_pkg::OFF_BUS_CMD, 32'h1e03);
    rchk(rcfe_pkg::OFF_STATUS, 32'h10);
    wchk(rcfe_pkg::OFF_QUERY, 32'h12345678);
    rchk(rcfe_pkg::OFF_STATUS, 32'h30);
    rchk(rcfe_pkg::OFF_QUERY, 32'h12345678);
    rchk(rcfe_pkg::OFF_STATUS, 32'h10);
    rdt(8'h24, rd, rs);
    chk({30'h0, rs}, {30'h0, rcfe_pkg::RESP_SLVERR});
    wchk(rcfe_pkg::OFF_GP_OUT, 32'h5);
    chk({29'h0, gpo}, 32'h5);
    plc.set_lines(5'h00, 1'b0, 5'h13, 4'ha);
    settle();
    rchk(rcfe_pkg::OFF_GP_IN, 32'ha);
    plc.set_lines(5'h00, 1'b1, 5'h13, 4'ha);
    settle();
    chk({26'h0, load_seen, sidx}, 32'h33);
    plc.set_lines(5'h01, 1'b0, 5'h13, 4'ha);
    settle();
    chk({31'h0, busy}, 32'h1);
    rchk(rcfe_pkg::OFF_GP_IN, 32'h0);
    wchk(rcfe_pkg::OFF_GP_OUT, 32'h2);
    chk({29'h0, gpo}, 32'h5);
    wchk(rcfe_pkg::OFF_MEAS, 32'h11);
    repeat (3) @(posedge aclk);
    chk({21'h0, fault, verdict, relay}, 32'h84);
    plc.set_lines(5'h03, 1'b0, 5'h13, 4'ha);
    settle();
    chk({31'h0, fact[1]}, 32'h1);
    plc.set_contact(1'b1);
    plc.set_lines(5'h01, 1'b0, 5'h13, 4'ha);
    settle();
    chk({31'h0, fact[1]}, 32'h0);
    chk({31'h0, busy}, 32'h1);
    wchk(rcfe_pkg::OFF_MEAS, 32'ha3);
    repeat (3) @(posedge aclk);
    chk({20'h0, busy, fault, verdict, relay}, 32'h610);
    results();
  end
endmodule
